// [logic/ext_mode_register.sv]
// Extended mode register: command decode, storage, retention mask and refresh pacing
`timescale 1ns/10ps
module ext_mode_register
  import ext_mode_pkg::*;
#(
  parameter int HOT_CYCLES  = REFRESH_HOT_CYC,
  parameter int COOL_CYCLES = REFRESH_COOL_CYC
) (
  input  wire logic              clk_i,
  input  wire logic              reset_n_i,
  input  wire logic              cs_n_i,
  input  wire logic              ras_n_i,
  input  wire logic              cas_n_i,
  input  wire logic              we_n_i,
  input  wire logic              bank_select_low_bit_i,
  input  wire logic              bank_select_high_bit_i,
  input  wire logic [ADDR_W-1:0] addr_i,
  input  wire logic              all_banks_idle_i,
  input  wire logic              self_refresh_i,
  input  wire logic              temp_hot_i,
  input  wire logic [1:0]        temp_compensated_refresh_i,
  output logic [ADDR_W-1:0]      extended_mode_settings_o,
  output logic [RETAIN_W-1:0]    partial_retention_refresh_o,
  output logic [DRIVE_W-1:0]     drive_strength_o,
  output logic [BANKS-1:0]       bank_retained_o,
  output logic                   load_busy_o,
  output logic                   base_mode_load_o,
  output logic                   refresh_tick_o
);

  initial begin
    if (HOT_CYCLES < 2 || COOL_CYCLES < 2 || HOT_CYCLES > 65535 || COOL_CYCLES > 65535)
      $error("refresh interval counts out of range");
    if (LOAD_CYCLES < 1 || LOAD_CYCLES > 3)
      $error("write window does not fit the two-bit counter");
  end

  localparam int PIN_W = ADDR_W + 6;

  logic [1:0]            rst_sync_ff;
  logic                  rst_n;
  logic [PIN_W-1:0]      pin_s1_ff;
  logic [PIN_W-1:0]      pin_s2_ff;
  logic [ADDR_W-1:0]     ext_mode_ff;
  logic [ADDR_W-1:0]     nxt_ext_mode;
  logic [1:0]            busy_cnt_ff;
  logic [1:0]            nxt_busy_cnt;
  logic                  base_load_ff;
  logic [15:0]           tick_cnt_ff;
  logic [15:0]           nxt_tick_cnt;
  logic                  tick_ff;
  wire  logic            strobes_low;
  wire  logic            ext_decode;
  wire  logic            base_decode;
  wire  logic            accept;
  wire  logic [ADDR_W-1:0] addr_s;
  wire  logic [15:0]     tick_limit;
  wire  logic [RETAIN_W-1:0] retain_code;

  // Reset release through two flops so deassertion is clean
  always_ff @(posedge clk_i or negedge reset_n_i) begin
    if (!reset_n_i) begin
      rst_sync_ff <= 2'h0;
    end else begin
      rst_sync_ff <= {rst_sync_ff[0], 1'b1};
    end
  end
  assign rst_n = rst_sync_ff[1];

  // Pin bundle synchroniser; only the second stage feeds logic
  always_ff @(posedge clk_i or negedge rst_n) begin
    if (!rst_n) begin
      // Idle value keeps the decoder quiet while the pins settle
      pin_s1_ff <= PIN_IDLE;
      pin_s2_ff <= PIN_IDLE;
    end else begin
      pin_s1_ff <= {cs_n_i, ras_n_i, cas_n_i, we_n_i,
                    bank_select_high_bit_i, bank_select_low_bit_i, addr_i};
      pin_s2_ff <= pin_s1_ff;
    end
  end

  // Command decode
  assign addr_s      = pin_s2_ff[ADDR_W-1:0];
  assign strobes_low = (pin_s2_ff[PIN_W-1 -: 4] == 4'h0);
  // R1: extended decode
  assign ext_decode  = strobes_low && pin_s2_ff[ADDR_W+1] && !pin_s2_ff[ADDR_W];
  // R13: base decode
  assign base_decode = strobes_low && !pin_s2_ff[ADDR_W+1] && !pin_s2_ff[ADDR_W];
  // R5: idle banks only
  // Loads during a busy window or with open banks are dropped, not queued
  assign accept      = ext_decode && all_banks_idle_i && (busy_cnt_ff == 2'h0);

  // R3: capture all fourteen lines
  assign nxt_ext_mode = accept ? addr_s : ext_mode_ff;
  // R4: two cycle write window
  // A counter keeps the window length in one constant
  assign nxt_busy_cnt = accept ? 2'(LOAD_CYCLES) :
                        (busy_cnt_ff != 2'h0) ? busy_cnt_ff - 2'h1 : 2'h0;

  // R15: zero after reset
  always_ff @(posedge clk_i or negedge rst_n) begin
    if (!rst_n) begin
      ext_mode_ff  <= EXT_MODE_RESET;
      busy_cnt_ff  <= 2'h0;
      base_load_ff <= 1'b0;
    end else begin
      ext_mode_ff  <= nxt_ext_mode;
      busy_cnt_ff  <= nxt_busy_cnt;
      base_load_ff <= base_decode;
    end
  end

  // Field outputs
  assign extended_mode_settings_o    = ext_mode_ff;
  // R6: retention field
  assign retain_code                 = ext_mode_ff[RETAIN_LSB +: RETAIN_W];
  assign partial_retention_refresh_o = retain_code;
  // R7: driver strength field
  assign drive_strength_o            = ext_mode_ff[DRIVE_LSB +: DRIVE_W];
  assign load_busy_o                 = (busy_cnt_ff != 2'h0);
  assign base_mode_load_o            = base_load_ff;

  // R12: three retention choices
  // R14: low banks kept; unknown codes fall back to full so no data is lost
  assign bank_retained_o = (retain_code == RETAIN_HALF)    ? MASK_HALF :
                           (retain_code == RETAIN_QUARTER) ? MASK_QUARTER : MASK_FULL;

  // R10: sensor picks the interval
  // R11: stored and pin temperature codes never reach the pacing logic
  // A sensor change applies to the running count, so one interval may differ
  assign tick_limit   = temp_hot_i ? 16'(HOT_CYCLES - 1) : 16'(COOL_CYCLES - 1);
  assign nxt_tick_cnt = (!self_refresh_i || tick_cnt_ff >= tick_limit) ? 16'h0000
                        : tick_cnt_ff + 16'h0001;

  // Self refresh pacing; restarts from zero on each entry
  always_ff @(posedge clk_i or negedge rst_n) begin
    if (!rst_n) begin
      tick_cnt_ff <= 16'h0000;
      tick_ff     <= 1'b0;
    end else begin
      tick_cnt_ff <= nxt_tick_cnt;
      tick_ff     <= self_refresh_i && (tick_cnt_ff >= tick_limit);
    end
  end
  assign refresh_tick_o = tick_ff;

  // Checks
  ext_decode_a: assert property (@(posedge clk_i) disable iff (!rst_n) // R1
    accept |-> pin_s2_ff[PIN_W-1 -: 6] == 6'h02 && all_banks_idle_i)
    else $error("extended load taken without its command code");
  load_store_a: assert property (@(posedge clk_i) disable iff (!rst_n) // R3
    accept |=> ext_mode_ff == $past(addr_s))
    else $error("register did not capture address lines");
  busy_window_a: assert property (@(posedge clk_i) disable iff (!rst_n) // R4
    accept |=> load_busy_o [*2] ##1 !load_busy_o)
    else $error("write window is not two cycles");
  idle_only_a: assert property (@(posedge clk_i) disable iff (!rst_n) // R5
    (ext_decode && !all_banks_idle_i) |=> $stable(ext_mode_ff))
    else $error("load taken while banks active");
  retain_field_a: assert property (@(posedge clk_i) disable iff (!rst_n) // R6
    accept |=> partial_retention_refresh_o == $past(addr_s[RETAIN_LSB +: RETAIN_W]))
    else $error("retention field wrong");
  drive_field_a: assert property (@(posedge clk_i) disable iff (!rst_n) // R7
    accept |=> drive_strength_o == $past(addr_s[7:5]))
    else $error("drive field wrong");
  hot_interval_a: assert property (@(posedge clk_i) disable iff (!rst_n) // R10
    (self_refresh_i && temp_hot_i && tick_cnt_ff >= tick_limit) |=> refresh_tick_o)
    else $error("refresh tick missing at interval end");
  temp_ignored_a: assert property (@(posedge clk_i) disable iff (!rst_n) // R11
    (self_refresh_i && !temp_hot_i && tick_cnt_ff < 16'(COOL_CYCLES - 1))
    |=> !refresh_tick_o)
    else $error("tick before the cool interval ended");
  retain_mask_a: assert property (@(posedge clk_i) disable iff (!rst_n) // R12
    (retain_code == RETAIN_QUARTER) |-> bank_retained_o == MASK_QUARTER)
    else $error("quarter mask wrong");
  low_banks_a: assert property (@(posedge clk_i) disable iff (!rst_n) // R14
    bank_retained_o[0] && (!bank_retained_o[2] || bank_retained_o[1]) &&
    (!bank_retained_o[3] || bank_retained_o[2]))
    else $error("retained region not low banks");
  base_distinct_a: assert property (@(posedge clk_i) disable iff (!rst_n) // R13
    base_decode |=> base_mode_load_o && $stable(ext_mode_ff))
    else $error("base load disturbed extended register");
  reset_zero_a: assert property (@(posedge clk_i) // R15
    $rose(rst_n) |-> ext_mode_ff == EXT_MODE_RESET)
    else $error("register not zero after reset");

  // Refusal and hold checks
  hold_value_a: assert property (@(posedge clk_i) disable iff (!rst_n) // R3
    !accept |=> $stable(ext_mode_ff))
    else $error("register changed without a taken load");
  busy_refuse_a: assert property (@(posedge clk_i) disable iff (!rst_n) // R4
    (ext_decode && load_busy_o) |=> $stable(ext_mode_ff))
    else $error("load taken inside the write window");
  busy_bound_a: assert property (@(posedge clk_i) disable iff (!rst_n) // R4
    busy_cnt_ff <= 2'(LOAD_CYCLES))
    else $error("write window counter out of range");
  base_pulse_a: assert property (@(posedge clk_i) disable iff (!rst_n) // R13
    !base_decode |=> !base_mode_load_o)
    else $error("base load pulse without its command");

  // Retention and pacing checks
  half_mask_a: assert property (@(posedge clk_i) disable iff (!rst_n) // R12
    (retain_code == RETAIN_HALF) |-> bank_retained_o == MASK_HALF)
    else $error("half mask wrong");
  full_mask_a: assert property (@(posedge clk_i) disable iff (!rst_n) // R12
    (retain_code == RETAIN_FULL) |-> bank_retained_o == MASK_FULL)
    else $error("full mask wrong");
  cool_interval_a: assert property (@(posedge clk_i) disable iff (!rst_n) // R10
    (self_refresh_i && !temp_hot_i && tick_cnt_ff >= tick_limit) |=> refresh_tick_o)
    else $error("cool refresh tick missing at interval end");
  tick_pulse_a: assert property (@(posedge clk_i) disable iff (!rst_n) // R10
    refresh_tick_o |=> !refresh_tick_o)
    else $error("refresh tick longer than one cycle");
  idle_no_tick_a: assert property (@(posedge clk_i) disable iff (!rst_n) // R10
    !self_refresh_i |=> !refresh_tick_o)
    else $error("refresh tick outside self refresh");

  // Reset checks
  reset_quiet_a: assert property (@(posedge clk_i) // R15
    $rose(rst_n) |-> !load_busy_o && !base_mode_load_o && !refresh_tick_o)
    else $error("outputs not idle after reset");

endmodule

// [logic/ext_mode_pkg.sv]
// Constants for the extended mode register path of the low-power DRAM die
//
// Contract
// R1: Extended load: four low strobes, high bank bit set, low bank bit clear.
// R2: Controller issues the extended load only with banks precharged and clock enable high.
// R3: Address lines 0 to 13 of the command cycle become the new register contents.
// R4: The write takes two clock cycles; no following command before they elapse.
// R5: Rewrite allowed any time after initialisation, only while every bank is idle.
// R6: Address bits 0 to 2 select the self refresh retention region.
// R7: Address bits 5 to 7 select the output driver strength.
// R8: Controller drives all other address lines low during the extended load.
// R9: Reserved fields are written as zero in every load.
// R10: Self refresh interval follows the internal temperature sensor automatically.
// R11: Any controller temperature compensation setting is ignored.
// R12: Retention choices are full, half or quarter of the array.
// R13: Base mode load uses both bank bits low, unlike the extended load.
// R14: Partial retention keeps low-numbered banks; other banks lose contents.
// R15: After reset the register is all zero: full retention, default drive.
package ext_mode_pkg;

  localparam int ADDR_W       = 14;
  localparam int BANKS        = 4;
  // Field positions inside the stored word
  localparam int RETAIN_LSB   = 0;
  localparam int RETAIN_W     = 3;
  localparam int TEMP_LSB     = 3;
  localparam int TEMP_W       = 2;
  localparam int DRIVE_LSB    = 5;
  localparam int DRIVE_W      = 3;
  localparam logic [ADDR_W-1:0] EXT_MODE_RESET = 14'h0000;

  // Retention region codes
  localparam logic [RETAIN_W-1:0] RETAIN_FULL    = 3'h0;
  localparam logic [RETAIN_W-1:0] RETAIN_HALF    = 3'h1;
  localparam logic [RETAIN_W-1:0] RETAIN_QUARTER = 3'h2;
  localparam logic [BANKS-1:0] MASK_FULL    = 4'hf;
  localparam logic [BANKS-1:0] MASK_HALF    = 4'h3;
  localparam logic [BANKS-1:0] MASK_QUARTER = 4'h1;

  // Timing
  localparam int CLK_PERIOD_NS     = 100;
  localparam int LOAD_CYCLES       = 2;
  localparam int REFRESH_HOT_NS    = 7800;
  localparam int REFRESH_HOT_CYC   = REFRESH_HOT_NS / CLK_PERIOD_NS;
  localparam int COOL_STRETCH      = 4;
  localparam int REFRESH_COOL_CYC  = REFRESH_HOT_CYC * COOL_STRETCH;

  // Idle level of the synchronised pin bundle: strobes high, banks and address low
  localparam logic [ADDR_W+5:0] PIN_IDLE = 20'hf0000;

endpackage

// [test/ctrl_model.sv]
// Controller model that drives the command and address pins
`timescale 1ns/10ps
module ctrl_model
  import ext_mode_pkg::*;
(
  input  wire logic              clk_i,
  input  wire logic              go_i,
  input  wire logic              base_i,
  input  wire logic [ADDR_W-1:0] addr_i,
  input  wire logic              lo_i,
  output logic                   cmd_n_o,
  output logic                   bank_hi_o,
  output logic                   bank_lo_o,
  output logic [ADDR_W-1:0]      addr_o
);
  initial {cmd_n_o, bank_hi_o, bank_lo_o, addr_o} = {3'b100, 14'h0000};
  // strobes high, bank bits, unused lines low
  // Deselected address lines toggle so stale values never look valid
  always @(posedge clk_i) begin
    cmd_n_o   <= !go_i;
    bank_hi_o <= go_i && !base_i;
    bank_lo_o <= go_i && lo_i;
    addr_o    <= go_i ? (addr_i & 14'h00e7) : ~addr_o;
  end
endmodule

// [test/test_ext_mode_register.sv]
// Self-checking bench for the extended mode register
`timescale 1ns/10ps
module test_ext_mode_register;
  import ext_mode_pkg::*;
  logic              clk_i = 0, reset_n_i = 0, go = 0, base = 0, idle = 1, lo = 0;
  logic              sr = 0, hot = 1, cmd_n, bank_hi, bank_lo, busy, base_pulse, tick;
  logic [1:0]        tcomp = 2'h0;
  logic [ADDR_W-1:0] wr = 14'h0000, pins, settings;
  logic [2:0]        retain, drive;
  logic [3:0]        banks;
  int                failures = 0, checked = 0, model = 0;
  int unsigned       seed = 32'h80713259;

  ctrl_model ctrl_model_i (.clk_i(clk_i), .go_i(go), .base_i(base), .addr_i(wr),
    .lo_i(lo), .cmd_n_o(cmd_n), .bank_hi_o(bank_hi), .bank_lo_o(bank_lo),
    .addr_o(pins));
  ext_mode_register #(.HOT_CYCLES(4), .COOL_CYCLES(8)) ext_mode_register_i (
    .clk_i(clk_i), .reset_n_i(reset_n_i), .cs_n_i(cmd_n), .ras_n_i(cmd_n),
    .cas_n_i(cmd_n), .we_n_i(cmd_n), .bank_select_low_bit_i(bank_lo),
    .bank_select_high_bit_i(bank_hi), .addr_i(pins), .all_banks_idle_i(idle),
    .self_refresh_i(sr), .temp_hot_i(hot), .temp_compensated_refresh_i(tcomp),
    .extended_mode_settings_o(settings), .partial_retention_refresh_o(retain),
    .drive_strength_o(drive), .bank_retained_o(banks), .load_busy_o(busy),
    .base_mode_load_o(base_pulse), .refresh_tick_o(tick));

  // Clock at 100 ns
  always #50 clk_i = ~clk_i;

  function automatic int unsigned lfsr(input int unsigned s);
    return {s[30:0], s[31] ^ s[21] ^ s[1] ^ s[0]};
  endfunction

  task automatic cmp(input logic [31:0] got, input int e, input string what);
    checked++;
    if (got !== 32'(e)) begin
      failures++;
      $display("CHECK FAILED %0t %s", $time, what);
    end
  endtask

  // Register outputs against the model word
  task automatic chk_regs;
    cmp(settings, model, "settings");
    cmp(retain, model & 7, "retention field");
    cmp(drive, (model >> 5) & 7, "drive field");
    cmp(banks, (model & 7) == RETAIN_HALF ? MASK_HALF :
               (model & 7) == RETAIN_QUARTER ? MASK_QUARTER : MASK_FULL, "banks");
  endtask

  // Go stays high when keep is set, so two commands land back to back
  task automatic issue(input logic b, input logic [ADDR_W-1:0] a, input bit keep);
    go <= 1'b1;
    base <= b;
    wr <= a;
    @(posedge clk_i);
    if (!keep) go <= 1'b0;
  endtask

  task automatic load(input logic b, input logic [ADDR_W-1:0] a, input bit take, input int eb);
    logic [31:0] nb, np;
    nb = 0;
    np = 0;
    issue(b, a, 0);
    repeat (8) begin
      @(posedge clk_i);
      nb += busy;
      np += base_pulse;
    end
    if (take) model = a;
    cmp(nb, eb, "busy length");
    cmp(np, b, "base pulse");
    chk_regs();
  endtask

  task automatic ticks(input logic s, input logic h, input int e);
    logic [31:0] n;
    n = 0;
    seed = lfsr(seed);
    tcomp <= seed[1:0];
    sr <= s;
    hot <= h;
    repeat (40) begin
      @(posedge clk_i);
      n += tick;
    end
    sr <= 1'b0;
    @(posedge clk_i);
    cmp(n + 32'd1 >= 32'(e) && n <= 32'(e), 1, "tick rate");
  endtask

  task automatic finish_test;
    if (failures == 0 && checked > 0) $display("Result: passed");
    else $display("Result: failed");
    $finish;
  endtask

  // Watchdog sized well above the roughly 250 cycles of the sequence
  initial begin
    repeat (3000) @(posedge clk_i);
    failures++;
    finish_test();
  end

  // Main sequence
  initial begin
    repeat (12) @(posedge clk_i);
    cmp(banks, 4'hf, "mask in reset");
    reset_n_i <= 1'b1;
    repeat (5) @(posedge clk_i);
    chk_regs();
    for (int c = 0; c < 8; c++) begin
      seed = lfsr(seed);
      tcomp <= seed[9:8];
      load(0, 14'(c) | (14'(seed[7:5]) << 5), 1, 2);
    end
    load(1, 14'h00e7, 0, 0);
    idle <= 1'b0;
    load(0, 14'h00a1, 0, 0);
    idle <= 1'b1;
    lo <= 1'b1;
    load(0, 14'h0063, 0, 0);
    lo <= 1'b0;
    issue(0, 14'h0042, 1);
    model = 14'h0042;
    load(0, 14'h0081, 0, 2);
    ticks(1, 1, 10);
    ticks(1, 0, 5);
    ticks(0, 1, 0);
    finish_test();
  end
endmodule
